// File: hw/ldf_pkg.sv
// constants and types for the display duty, power and frame interrupt block
`default_nettype none
package ldf_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int COM_W = 6;
    localparam int SEG_W = 7;
    localparam int IDX_W = 16;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DUTY = 16'h50A2;
    localparam logic [IDX_W-1:0] IDX_VREG = 16'h50A3;
    localparam logic [IDX_W-1:0] IDX_BOOST = 16'h50A4;
    localparam logic [IDX_W-1:0] IDX_MASK = 16'h50A5;
    localparam logic [IDX_W-1:0] IDX_FLAG = 16'h50A6;
    // field positions
    localparam int HVLD_BIT = 4;
    localparam int SRC_BIT = 1;
    localparam int BOOST_BIT = 0;
    localparam int IE_BIT = 0;
    localparam int IF_BIT = 0;
    // reset values
    localparam logic [1:0] DUTY_RST = 2'h2;
    localparam logic HVLD_RST = 1'h0;
    localparam logic SRC_RST = 1'h0;
    localparam logic BOOST_RST = 1'h0;
    localparam logic IE_RST = 1'h0;
    localparam logic IF_RST = 1'h0;
    // duty codes and active line counts
    localparam logic [1:0] DUTY_1_32 = 2'h2;
    localparam logic [1:0] DUTY_1_16 = 2'h1;
    localparam logic [COM_W-1:0] COM_1_32 = 6'h20;
    localparam logic [SEG_W-1:0] SEG_1_32 = 7'h38;
    localparam logic [COM_W-1:0] COM_1_16 = 6'h10;
    localparam logic [SEG_W-1:0] SEG_1_16 = 7'h48;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DUTY,
        SEL_VREG,
        SEL_BOOST,
        SEL_MASK,
        SEL_FLAG
    } ldf_sel_t;
endpackage : ldf_pkg
`default_nettype wire

// File: hw/ldf_top.sv
// display duty select, power controls and frame interrupt with axi4-lite
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - two-bit duty field, reset 2; 2 is 1/32 duty, 1 is 1/16 duty
// - heavy-load protection bit at bit 4 of regulator control, reset 0
// - regulator source select at bit 1 of booster control, reset 0
// - booster enable at bit 0 of booster control, reset 0
// - frame interrupt enable at bit 0 of mask register, reset 0
// - frame flag sets on every rising frame edge, enable or not
// - interrupt request high while flag and enable are both one
// - writing one to flag bit 0 clears it; writing zero does nothing
module ldf_top (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic FRAME_I,
    input wire logic [ldf_pkg::ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [ldf_pkg::DATA_W-1:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [ldf_pkg::ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [ldf_pkg::DATA_W-1:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [1:0] DRIVE_DUTY_SEL_O,
    output logic [ldf_pkg::COM_W-1:0] COMMON_LINES_O,
    output logic [ldf_pkg::SEG_W-1:0] SEGMENT_LINES_O,
    output logic HEAVY_LOAD_PROTECT_O,
    output logic REGULATOR_SOURCE_SEL_O,
    output logic BOOSTER_ON_O,
    output logic FRAME_IRQ_O
);
    import ldf_pkg::*;

    // low two address bits ignored; word index compared whole
    function automatic ldf_sel_t ldf_decode(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        idx = a[ADDR_W-1:2];
        case (idx)
            IDX_DUTY: ldf_decode = SEL_DUTY;
            IDX_VREG: ldf_decode = SEL_VREG;
            IDX_BOOST: ldf_decode = SEL_BOOST;
            IDX_MASK: ldf_decode = SEL_MASK;
            IDX_FLAG: ldf_decode = SEL_FLAG;
            default: ldf_decode = SEL_NONE;
        endcase
    endfunction : ldf_decode

    // reserved codes drive no lines
    function automatic logic [COM_W-1:0] ldf_com(input logic [1:0] d);
        case (d)
            DUTY_1_32: ldf_com = COM_1_32;
            DUTY_1_16: ldf_com = COM_1_16;
            default: ldf_com = '0;
        endcase
    endfunction : ldf_com

    function automatic logic [SEG_W-1:0] ldf_seg(input logic [1:0] d);
        case (d)
            DUTY_1_32: ldf_seg = SEG_1_32;
            DUTY_1_16: ldf_seg = SEG_1_16;
            default: ldf_seg = '0;
        endcase
    endfunction : ldf_seg

    // bus state
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic do_wr, ar_acc;
    ldf_sel_t wsel, rsel;

    // control state
    logic [1:0] duty_r, duty_nxt;
    logic hvld_r, hvld_nxt;
    logic src_r, src_nxt;
    logic boost_r, boost_nxt;
    logic ie_r, ie_nxt;
    logic flag_r, flag_nxt;
    logic frame_d_r, frame_d_nxt;
    logic irq_r, irq_nxt;
    logic [COM_W-1:0] com_r, com_nxt;
    logic [SEG_W-1:0] seg_r, seg_nxt;
    logic frame_rise, flag_clr;

    always_comb begin
        wsel = ldf_decode(awaddr_r);
        rsel = ldf_decode(ARADDR_I);
        // write waits for both halves and a free response slot
        do_wr = aw_held_r & w_held_r & ~bvalid_r;
        ar_acc = ARVALID_I & arready_r;
        aw_held_nxt = (aw_held_r & ~do_wr) | (AWVALID_I & awready_r);
        w_held_nxt = (w_held_r & ~do_wr) | (WVALID_I & wready_r);
        awaddr_nxt = (AWVALID_I & awready_r) ? AWADDR_I : awaddr_r;
        wdata_nxt = (WVALID_I & wready_r) ? WDATA_I[7:0] : wdata_r;
        wstrb_nxt = (WVALID_I & wready_r) ? WSTRB_I[0] : wstrb_r;
        awready_nxt = ~aw_held_nxt;
        wready_nxt = ~w_held_nxt;
        bvalid_nxt = do_wr | (bvalid_r & ~BREADY_I);
        bresp_nxt = bresp_r;
        if (do_wr) begin
            bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        rvalid_nxt = ar_acc | (rvalid_r & ~RREADY_I);
        arready_nxt = ~rvalid_nxt;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (ar_acc) begin
            rresp_nxt = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            rdata_nxt = 8'h00;
            case (rsel)
                SEL_DUTY: rdata_nxt[1:0] = duty_r;
                SEL_VREG: rdata_nxt[HVLD_BIT] = hvld_r;
                SEL_BOOST: begin
                    rdata_nxt[SRC_BIT] = src_r;
                    rdata_nxt[BOOST_BIT] = boost_r;
                end
                SEL_MASK: rdata_nxt[IE_BIT] = ie_r;
                SEL_FLAG: rdata_nxt[IF_BIT] = flag_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 8'h00;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        // frame comes from the drive core on this clock; no synchroniser
        frame_d_nxt = FRAME_I;
        frame_rise = FRAME_I & ~frame_d_r;
        flag_clr = do_wr & wstrb_r & (wsel == SEL_FLAG) & wdata_r[IF_BIT];
        duty_nxt = duty_r;
        hvld_nxt = hvld_r;
        src_nxt = src_r;
        boost_nxt = boost_r;
        ie_nxt = ie_r;
        if (do_wr && wstrb_r) begin
            case (wsel)
                SEL_DUTY: duty_nxt = wdata_r[1:0];
                SEL_VREG: hvld_nxt = wdata_r[HVLD_BIT];
                SEL_BOOST: begin
                    src_nxt = wdata_r[SRC_BIT];
                    boost_nxt = wdata_r[BOOST_BIT];
                end
                SEL_MASK: ie_nxt = wdata_r[IE_BIT];
                default: ie_nxt = ie_r;
            endcase
        end
        // a rising edge in the clearing cycle wins, so no frame is lost
        flag_nxt = frame_rise | (flag_r & ~flag_clr);
        // level request; relies on a level-sensitive controller
        irq_nxt = flag_nxt & ie_nxt;
        com_nxt = ldf_com(duty_nxt);
        seg_nxt = ldf_seg(duty_nxt);
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            duty_r <= DUTY_RST;
            hvld_r <= HVLD_RST;
            src_r <= SRC_RST;
            boost_r <= BOOST_RST;
            ie_r <= IE_RST;
            flag_r <= IF_RST;
            irq_r <= 1'b0;
            com_r <= COM_1_32;
            seg_r <= SEG_1_32;
        end else begin
            duty_r <= duty_nxt;
            hvld_r <= hvld_nxt;
            src_r <= src_nxt;
            boost_r <= boost_nxt;
            ie_r <= ie_nxt;
            flag_r <= flag_nxt;
            irq_r <= irq_nxt;
            com_r <= com_nxt;
            seg_r <= seg_nxt;
        end
    end

    // edge history runs through reset: a frame already high at release
    // must not look like a fresh rising edge
    always_ff @(posedge CLOCK_I) begin
        frame_d_r <= frame_d_nxt;
    end

    assign AWREADY_O = awready_r;
    assign WREADY_O = wready_r;
    assign BVALID_O = bvalid_r;
    assign BRESP_O = bresp_r;
    assign ARREADY_O = arready_r;
    assign RVALID_O = rvalid_r;
    assign RRESP_O = rresp_r;
    assign RDATA_O = {24'h000000, rdata_r};
    assign DRIVE_DUTY_SEL_O = duty_r;
    assign COMMON_LINES_O = com_r;
    assign SEGMENT_LINES_O = seg_r;
    assign HEAVY_LOAD_PROTECT_O = hvld_r;
    assign REGULATOR_SOURCE_SEL_O = src_r;
    assign BOOSTER_ON_O = boost_r;
    assign FRAME_IRQ_O = irq_r;

    default clocking ck @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    sequence wr_vreg_s;
        do_wr && wstrb_r && wsel == SEL_VREG;
    endsequence
    sequence wr_boost_s;
        do_wr && wstrb_r && wsel == SEL_BOOST;
    endsequence
    sequence flag_clear_s;
        flag_clr && !frame_rise;
    endsequence

    duty_lines_a: assert property (
        ##1 (COMMON_LINES_O == ldf_com(DRIVE_DUTY_SEL_O)
            && SEGMENT_LINES_O == ldf_seg(DRIVE_DUTY_SEL_O)))
        else $error("line counts disagree with duty");
    heavy_load_wr_a: assert property (
        wr_vreg_s |=> HEAVY_LOAD_PROTECT_O == $past(wdata_r[HVLD_BIT]))
        else $error("protection bit not written");
    source_sel_wr_a: assert property (
        wr_boost_s |=> REGULATOR_SOURCE_SEL_O == $past(wdata_r[SRC_BIT]))
        else $error("source select not written");
    booster_wr_a: assert property (
        wr_boost_s |=> BOOSTER_ON_O == $past(wdata_r[BOOST_BIT]))
        else $error("booster bit not written");
    irq_masked_a: assert property (
        !ie_r |-> !FRAME_IRQ_O)
        else $error("request raised while disabled");
    flag_set_a: assert property (
        $rose(FRAME_I) |=> flag_r)
        else $error("frame edge did not set flag");
    irq_follow_a: assert property (
        (frame_rise && ie_r && !(do_wr && wsel == SEL_MASK)) |=> FRAME_IRQ_O
            ##0 (FRAME_IRQ_O && flag_r) [*1])
        else $error("request missing with flag and enable");
    flag_clear_a: assert property (
        flag_clear_s |=> !flag_r ##0 !FRAME_IRQ_O)
        else $error("write one did not clear flag");
    flag_keep_a: assert property (
        (flag_r && do_wr && wsel == SEL_FLAG && !wdata_r[IF_BIT])
            |=> flag_r)
        else $error("write zero cleared flag");
    resv_zero_a: assert property (
        RVALID_O |-> (RDATA_O[31:5] == 27'h0000000
            && RDATA_O[3:2] == 2'h0
            && (rresp_r == RESP_OKAY || RDATA_O == 32'h00000000)))
        else $error("reserved read bits not zero");
    wr_answer_a: assert property (
        (AWVALID_I && awready_r && WVALID_I && wready_r && !bvalid_r)
            |-> ##2 BVALID_O)
        else $error("write answer late");
endmodule : ldf_top
`default_nettype wire

// File: testbench/ldf_intc_model.sv
// level-sensitive interrupt controller stand-in for the frame request
`timescale 1ns/1ns
`default_nettype none
module ldf_intc_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    output logic pending_o
);
    logic pending_nxt;
    // level trigger: pending drops one clock after the source clears
    always_comb begin
        pending_nxt = req_i;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_o <= 1'h0;
        end else begin
            pending_o <= pending_nxt;
        end
    end
endmodule : ldf_intc_model
`default_nettype wire

// File: testbench/test_ldf_top.sv
// self-checking bench for the duty, power and frame interrupt block
`timescale 1ns/1ns
`default_nettype none
module test_ldf_top;
    import ldf_pkg::*;
    typedef struct {
        logic [IDX_W-1:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [17:0] outs;
    } ldf_row_t;
    localparam logic [14:0] D32 = {DUTY_1_32, COM_1_32, SEG_1_32};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic frame = 1'h0;
    logic [ADDR_W-1:0] awaddr = 18'h0;
    logic [ADDR_W-1:0] araddr = 18'h0;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, pending;
    logic hvld, src, boost;
    logic [1:0] bresp, rresp, duty, resp;
    logic [COM_W-1:0] common_drive_line;
    logic [SEG_W-1:0] segment_drive_line;
    logic [17:0] outs;
    logic [31:0] rd;
    int err_count = 0;
    int num_checks = 0;
    ldf_row_t rows [9] = '{
        '{IDX_DUTY, 8'hFF, 8'h03, {2'h3, 6'h00, 7'h00, 3'h0}},
        '{IDX_DUTY, 8'h01, 8'h01, {DUTY_1_16, COM_1_16, SEG_1_16, 3'h0}},
        '{IDX_DUTY, 8'h00, 8'h00, {2'h0, 6'h00, 7'h00, 3'h0}},
        '{IDX_DUTY, 8'h02, 8'h02, {D32, 3'h0}},
        '{IDX_VREG, 8'hFF, 8'h10, {D32, 3'h4}},
        '{IDX_VREG, 8'hEF, 8'h00, {D32, 3'h0}},
        '{IDX_BOOST, 8'hFE, 8'h02, {D32, 3'h2}},
        '{IDX_BOOST, 8'h01, 8'h01, {D32, 3'h1}},
        '{IDX_BOOST, 8'h00, 8'h00, {D32, 3'h0}}};

    assign outs = {duty, common_drive_line, segment_drive_line, hvld, src, boost};
    always #25 clk = ~clk;

    ldf_top i_ldf_top (
        .CLOCK_I(clk), .RST_N_I(rst_n), .FRAME_I(frame),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready),
        .DRIVE_DUTY_SEL_O(duty), .COMMON_LINES_O(common_drive_line),
        .SEGMENT_LINES_O(segment_drive_line), .HEAVY_LOAD_PROTECT_O(hvld),
        .REGULATOR_SOURCE_SEL_O(src), .BOOSTER_ON_O(boost),
        .FRAME_IRQ_O(irq));
    ldf_intc_model i_ldf_intc_model (
        .clk_i(clk), .rst_n_i(rst_n), .req_i(irq), .pending_o(pending));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // a hung handshake is scored once, then the run is closed
    task automatic tmo(input int n);
        if (n >= 40) begin
            chk(32'h0, 32'h1);
            finish_test();
        end
    endtask : tmo

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        int n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'h0;
        w = 1'h0;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (!aw && awready) begin
                aw = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w && wready) begin
                w = 1'h1;
                wvalid <= 1'h0;
            end
        end while (!(aw && w) && n < 40);
        do begin
            @(posedge clk);
            n++;
        end while (!bvalid && n < 40);
        resp = bresp;
        bready <= 1'h0;
        tmo(n);
    endtask : wr

    task automatic rdr(input logic [IDX_W-1:0] idx);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (!arready && n < 40);
        arvalid <= 1'h0;
        do begin
            @(posedge clk);
            n++;
        end while (!rvalid && n < 40);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
        tmo(n);
    endtask : rdr

    // request output may lag its cause by a register stage
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic rise;
        frame <= 1'h0;
        @(posedge clk);
        frame <= 1'h1;
        repeat (2) @(posedge clk);
    endtask : rise

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk(outs, {D32, 3'h0});
        chk(irq, 1'h0);
        for (int i = 0; i < 5; i++) begin
            rdr(IDX_W'(IDX_DUTY + i));
            chk(rd, (i == 0) ? 32'h2 : 32'h0);
        end
        $display("done reset");
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].idx, rows[i].wd);
            chk(resp, RESP_OKAY);
            chk(outs, rows[i].outs);
            rdr(rows[i].idx);
            chk(rd, rows[i].rd);
            chk(resp, RESP_OKAY);
        end
        $display("done table");
        wstrb <= 4'h0;
        wr(IDX_DUTY, 8'h01);
        wstrb <= 4'hF;
        rdr(IDX_DUTY);
        chk(rd, 32'h2);
        wr(16'h50A7, 8'h01);
        chk(resp, RESP_SLVERR);
        rdr(16'h50A1);
        chk(rd, 32'h0);
        chk(resp, RESP_SLVERR);
        $display("done bus");
        rise();
        @(negedge clk);
        chk(irq, 1'h0);
        rdr(IDX_FLAG);
        chk(rd, 32'h1);
        wr(IDX_FLAG, 8'hFE);
        rdr(IDX_FLAG);
        chk(rd, 32'h1);
        wr(IDX_FLAG, 8'h01);
        wr(IDX_MASK, 8'h01);
        settle();
        chk(irq, 1'h0);
        rise();
        chk(irq, 1'h1);
        @(posedge clk);
        chk(pending, 1'h1);
        wr(IDX_MASK, 8'h00);
        settle();
        chk(irq, 1'h0);
        wr(IDX_MASK, 8'h01);
        settle();
        chk(irq, 1'h1);
        wr(IDX_FLAG, 8'h01);
        settle();
        chk(irq, 1'h0);
        chk(pending, 1'h0);
        rise();
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk(irq, 1'h0);
        chk(outs, {D32, 3'h0});
        rdr(IDX_FLAG);
        chk(rd, 32'h0);
        rdr(IDX_MASK);
        chk(rd, 32'h0);
        $display("done frame");
        finish_test();
    end
endmodule : test_ldf_top
`default_nettype wire
